/* verilog/csb_pkg.sv */
// csb_pkg: constants shared by the sense blanking block.
// assumes a 100 MHz clock and a word-indexed register port.
package csb_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned SAMPLE_HZ = 128;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
	localparam int unsigned MS_DIV = CLK_HZ / MS_PER_S;
	localparam int unsigned AW = 8;
	localparam int unsigned TW = 10;
	localparam int unsigned DW = 16;
	localparam int unsigned RW = 4;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [TW-1:0] NOISE_INIT_MS = 10'h06e;
	localparam logic [TW-1:0] NOISE_REG_MS = 10'h00c;
	localparam logic [TW-1:0] LCH_APACE_MS = 10'h032;
	localparam logic [RW-1:0] ASYNC_RETRIG = 4'h8;
	// register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_UPPER_PCT = 4'h1;
	localparam logic [3:0] REG_LOWER_PCT = 4'h2;
	localparam logic [3:0] REG_MIN_THR = 4'h3;
	localparam logic [3:0] REG_UP_DUR_SENSE = 4'h4;
	localparam logic [3:0] REG_UP_DUR_PACE = 4'h5;
	localparam logic [3:0] REG_XBLANK_VP = 4'h6;
	localparam logic [3:0] REG_FARFIELD_VS = 4'h7;
	localparam logic [3:0] REG_ATR_PACE_BLANK = 4'h8;
	localparam logic [3:0] REG_RCH_APACE_BLANK = 4'h9;
	localparam logic [3:0] REG_RCH_PACE_BLANK = 4'ha;
	localparam logic [3:0] REG_LCH_PACE_BLANK = 4'hb;
	localparam logic [3:0] REG_TWAVE_PERIOD = 4'hc;
	localparam logic [3:0] REG_STATUS = 4'hd;
	localparam logic [3:0] REG_RCH_PEAK = 4'he;
	// control bits
	localparam int unsigned CTRL_ATR_EN = 0;
	localparam int unsigned CTRL_LCH_EN = 1;
	localparam int unsigned CTRL_THREE_CH = 2;
	localparam int unsigned CTRL_DUAL_SENSE = 3;
	localparam logic [3:0] CTRL_RST = 4'h3;
	// reset values
	localparam logic [6:0] UPPER_PCT_RST = 7'h32;
	localparam logic [6:0] LOWER_PCT_RST = 7'h19;
	localparam logic [AW-1:0] MIN_THR_RST = 8'h04;
	localparam logic [TW-1:0] UP_DUR_SENSE_RST = 10'h15e;
	localparam logic [TW-1:0] UP_DUR_PACE_RST = 10'h190;
	localparam logic [TW-1:0] XBLANK_VP_RST = 10'h020;
	localparam logic [TW-1:0] FARFIELD_VS_RST = 10'h064;
	localparam logic [TW-1:0] ATR_PACE_BLANK_RST = 10'h032;
	localparam logic [TW-1:0] RCH_APACE_RST = 10'h028;
	localparam logic [TW-1:0] RCH_PACE_RST = 10'h064;
	localparam logic [TW-1:0] LCH_PACE_RST = 10'h064;
	localparam logic [TW-1:0] TWAVE_RST = 10'h0c8;
	localparam int unsigned CH_ATR = 0;
	localparam int unsigned CH_RCH = 1;
	localparam int unsigned CH_LCH = 2;
endpackage

/* verilog/csb_sense_blanking.sv */
// csb_sense_blanking: blanking, noise and adaptive threshold sensing.
// assumes synchronous one-cycle pace pulses and sampled amplitudes.
// How it works
// - ventricular pace blanks atrium for programmed time
// - ventricular sense opens atrial far-field blanking
// - atrial pace blanks atrial channel, programmable
// - atrial pace blanks both ventricles, left fixed
// - right pace blanks right, left on three-chamber
// - left pace blanks both ventricles, three-chamber
// - senses inside noise excluded from rate
// - sense in 110 ms noise starts 12 ms
// - noise interval restarts on each sense
// - endless right-chamber noise restarts force asynchronous pacing
// - atrial off stops stream and recording
// - left off stops sensing, stream, recording
// - upper threshold is percent of peak
// - upper duration differs after sense, pace
// - lower threshold is percent of peak
// - minimum threshold floors every threshold
// - thresholds recomputed each beat, clamped
// - post-pace period keeps raised threshold
// - default thresholds fifty and twenty-five percent
// - default upper hold 350 or 400 ms
// - amplitudes sampled at 128 Hz
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module csb_channel import csb_pkg::*; (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// time base
	input wire logic ms_tick_in,
	input wire logic sample_tick_in,
	// channel inputs
	input wire logic enable_in,
	input wire logic [AW-1:0] amp_in,
	input wire logic pace_in,
	input wire logic [TW-1:0] blank_len_in,
	// settings
	input wire logic [6:0] upper_pct_in,
	input wire logic [6:0] lower_pct_in,
	input wire logic [AW-1:0] min_thr_in,
	input wire logic [TW-1:0] dur_sense_in,
	input wire logic [TW-1:0] dur_pace_in,
	input wire logic [TW-1:0] twave_in,
	// results
	output logic sense_out,
	output logic rate_out,
	output logic blanked_out,
	output logic noise_out,
	output logic async_out,
	output logic upper_out,
	output logic [AW-1:0] peak_out
);
	logic [TW-1:0] blank_q, blank_d, noise_q, noise_d;
	logic [TW-1:0] up_q, up_d, tw_q, tw_d;
	logic [AW-1:0] peak_q, peak_d, prev_q, prev_d, thr;
	logic [RW-1:0] retrig_q, retrig_d;
	logic sense_q, sense_d, rate_q, rate_d;
	logic [AW+6:0] up_prod, lo_prod;
	logic [AW-1:0] up_thr, lo_thr;
	logic [6:0] up_pct, lo_pct;
	logic hit;

	// threshold from last peak, floored by the minimum
	always_comb begin
		up_pct = (upper_pct_in > PCT_FULL) ? PCT_FULL : upper_pct_in;
		lo_pct = (lower_pct_in > PCT_FULL) ? PCT_FULL : lower_pct_in;
		up_prod = peak_q * up_pct;
		lo_prod = peak_q * lo_pct;
		up_thr = AW'(up_prod / PCT_FULL);
		lo_thr = AW'(lo_prod / PCT_FULL);
		if (up_q != '0 || tw_q != '0) begin
			thr = up_thr;
		end else begin
			thr = lo_thr;
		end
		if (thr < min_thr_in) begin
			thr = min_thr_in;
		end
		hit = sample_tick_in && enable_in && blank_q == '0 &&
			amp_in >= thr && prev_q < thr;
	end

	always_comb begin
		blank_d = blank_q;
		noise_d = noise_q;
		up_d = up_q;
		tw_d = tw_q;
		peak_d = peak_q;
		prev_d = prev_q;
		retrig_d = retrig_q;
		sense_d = 1'b0;
		rate_d = 1'b0;
		if (ms_tick_in) begin
			if (blank_q != '0) begin
				blank_d = blank_q - 1'b1;
			end
			if (noise_q != '0) begin
				noise_d = noise_q - 1'b1;
			end
			if (up_q != '0) begin
				up_d = up_q - 1'b1;
			end
			if (tw_q != '0) begin
				tw_d = tw_q - 1'b1;
			end
		end
		if (noise_d == '0) begin
			retrig_d = '0;
		end
		if (blank_len_in > blank_d) begin
			blank_d = blank_len_in;
		end
		if (sample_tick_in) begin
			prev_d = amp_in;
			if (up_q != '0 && amp_in > peak_q && blank_q == '0) begin
				peak_d = amp_in;
			end
		end
		if (pace_in) begin
			up_d = dur_pace_in;
			tw_d = twave_in;
		end
		if (hit) begin
			sense_d = 1'b1;
			peak_d = amp_in;
			up_d = dur_sense_in;
			if (noise_q != '0) begin
				noise_d = NOISE_REG_MS;
				if (retrig_q != ASYNC_RETRIG) begin
					retrig_d = retrig_q + 1'b1;
				end
			end else begin
				rate_d = 1'b1;
				noise_d = NOISE_INIT_MS;
				retrig_d = '0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			blank_q <= '0;
			noise_q <= '0;
			up_q <= '0;
			tw_q <= '0;
			peak_q <= '0;
			prev_q <= '0;
			retrig_q <= '0;
			sense_q <= 1'b0;
			rate_q <= 1'b0;
		end else begin
			blank_q <= blank_d;
			noise_q <= noise_d;
			up_q <= up_d;
			tw_q <= tw_d;
			peak_q <= peak_d;
			prev_q <= prev_d;
			retrig_q <= retrig_d;
			sense_q <= sense_d;
			rate_q <= rate_d;
		end
	end

	assign sense_out = sense_q;
	assign rate_out = rate_q;
	assign blanked_out = blank_q != '0;
	assign noise_out = noise_q != '0;
	assign async_out = retrig_q == ASYNC_RETRIG;
	assign upper_out = up_q != '0 || tw_q != '0;
	assign peak_out = peak_q;
endmodule

module csb_sense_blanking import csb_pkg::*; #(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_DIV,
	parameter int unsigned MS_CYCLES = MS_DIV,
	parameter logic [TW-1:0] LCH_APACE_LEN = LCH_APACE_MS
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [DW-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DW-1:0] reg_rdata_out,
	// pace events
	input wire logic atrial_pace_in,
	input wire logic right_chamber_pace_in,
	input wire logic left_chamber_pace_in,
	// sampled lead amplitudes
	input wire logic [AW-1:0] atrial_amp_in,
	input wire logic [AW-1:0] right_chamber_amp_in,
	input wire logic [AW-1:0] left_chamber_amp_in,
	// qualified events
	output logic atrial_sense_event_out,
	output logic atrial_rate_event_out,
	output logic ventricular_sense_event_out,
	output logic ventricular_rate_event_out,
	output logic left_chamber_sense_event_out,
	output logic async_pace_out,
	// waveform stream and recording enables
	output logic [2:0] intracardiac_waveform_stream_en_out,
	output logic [2:0] record_en_out
);
	logic [31:0] samp_cnt_q, samp_cnt_d, ms_cnt_q, ms_cnt_d;
	logic samp_tick, ms_tick;
	logic [3:0] ctrl_q, ctrl_d;
	logic [6:0] upct_q, upct_d, lpct_q, lpct_d;
	logic [AW-1:0] min_q, min_d;
	logic [TW-1:0] dsen_q, dsen_d, dpac_q, dpac_d, xvp_q, xvp_d;
	logic [TW-1:0] ffvs_q, ffvs_d, apb_q, apb_d, rap_q, rap_d;
	logic [TW-1:0] rpb_q, rpb_d, lpb_q, lpb_d, tw_q, tw_d;
	logic [DW-1:0] rdata_q, rdata_d;
	logic [2:0] stream_q, stream_d;
	logic [TW-1:0] len [3];
	logic [2:0] en, pace, sense, rate, blanked, noise, async_v, upper;
	logic [AW-1:0] amp [3];
	logic [AW-1:0] peak [3];
	logic three_ch, vpace;

	function automatic logic [TW-1:0] mx(input logic [TW-1:0] a,
		input logic [TW-1:0] b);
		mx = (a > b) ? a : b;
	endfunction

	// 128 Hz sample enable and 1 ms window enable
	always_comb begin
		samp_tick = samp_cnt_q == SAMPLE_CYCLES - 1;
		ms_tick = ms_cnt_q == MS_CYCLES - 1;
		samp_cnt_d = samp_tick ? '0 : samp_cnt_q + 1;
		ms_cnt_d = ms_tick ? '0 : ms_cnt_q + 1;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			samp_cnt_q <= '0;
			ms_cnt_q <= '0;
		end else begin
			samp_cnt_q <= samp_cnt_d;
			ms_cnt_q <= ms_cnt_d;
		end
	end

	// register writes and reads
	always_comb begin
		ctrl_d = ctrl_q;
		upct_d = upct_q;
		lpct_d = lpct_q;
		min_d = min_q;
		dsen_d = dsen_q;
		dpac_d = dpac_q;
		xvp_d = xvp_q;
		ffvs_d = ffvs_q;
		apb_d = apb_q;
		rap_d = rap_q;
		rpb_d = rpb_q;
		lpb_d = lpb_q;
		tw_d = tw_q;
		rdata_d = '0;
		if (reg_wr_in) begin
			case (reg_addr_in)
				REG_CTRL: ctrl_d = reg_wdata_in[3:0];
				REG_UPPER_PCT: upct_d = reg_wdata_in[6:0];
				REG_LOWER_PCT: lpct_d = reg_wdata_in[6:0];
				REG_MIN_THR: min_d = reg_wdata_in[AW-1:0];
				REG_UP_DUR_SENSE: dsen_d = reg_wdata_in[TW-1:0];
				REG_UP_DUR_PACE: dpac_d = reg_wdata_in[TW-1:0];
				REG_XBLANK_VP: xvp_d = reg_wdata_in[TW-1:0];
				REG_FARFIELD_VS: ffvs_d = reg_wdata_in[TW-1:0];
				REG_ATR_PACE_BLANK: apb_d = reg_wdata_in[TW-1:0];
				REG_RCH_APACE_BLANK: rap_d = reg_wdata_in[TW-1:0];
				REG_RCH_PACE_BLANK: rpb_d = reg_wdata_in[TW-1:0];
				REG_LCH_PACE_BLANK: lpb_d = reg_wdata_in[TW-1:0];
				REG_TWAVE_PERIOD: tw_d = reg_wdata_in[TW-1:0];
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				REG_CTRL: rdata_d = DW'(ctrl_q);
				REG_UPPER_PCT: rdata_d = DW'(upct_q);
				REG_LOWER_PCT: rdata_d = DW'(lpct_q);
				REG_MIN_THR: rdata_d = DW'(min_q);
				REG_UP_DUR_SENSE: rdata_d = DW'(dsen_q);
				REG_UP_DUR_PACE: rdata_d = DW'(dpac_q);
				REG_XBLANK_VP: rdata_d = DW'(xvp_q);
				REG_FARFIELD_VS: rdata_d = DW'(ffvs_q);
				REG_ATR_PACE_BLANK: rdata_d = DW'(apb_q);
				REG_RCH_APACE_BLANK: rdata_d = DW'(rap_q);
				REG_RCH_PACE_BLANK: rdata_d = DW'(rpb_q);
				REG_LCH_PACE_BLANK: rdata_d = DW'(lpb_q);
				REG_TWAVE_PERIOD: rdata_d = DW'(tw_q);
				REG_STATUS: rdata_d = DW'({async_pace_out, upper, noise,
					blanked});
				REG_RCH_PEAK: rdata_d = DW'(peak[CH_RCH]);
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q <= CTRL_RST;
			upct_q <= UPPER_PCT_RST;
			lpct_q <= LOWER_PCT_RST;
			min_q <= MIN_THR_RST;
			dsen_q <= UP_DUR_SENSE_RST;
			dpac_q <= UP_DUR_PACE_RST;
			xvp_q <= XBLANK_VP_RST;
			ffvs_q <= FARFIELD_VS_RST;
			apb_q <= ATR_PACE_BLANK_RST;
			rap_q <= RCH_APACE_RST;
			rpb_q <= RCH_PACE_RST;
			lpb_q <= LCH_PACE_RST;
			tw_q <= TWAVE_RST;
			rdata_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			upct_q <= upct_d;
			lpct_q <= lpct_d;
			min_q <= min_d;
			dsen_q <= dsen_d;
			dpac_q <= dpac_d;
			xvp_q <= xvp_d;
			ffvs_q <= ffvs_d;
			apb_q <= apb_d;
			rap_q <= rap_d;
			rpb_q <= rpb_d;
			lpb_q <= lpb_d;
			tw_q <= tw_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_out = rdata_q;

	// blanking lengths requested this cycle, zero when none
	always_comb begin
		three_ch = ctrl_q[CTRL_THREE_CH];
		vpace = right_chamber_pace_in || left_chamber_pace_in;
		len[CH_ATR] = mx(mx(vpace ? xvp_q : '0,
			sense[CH_RCH] ? ffvs_q : '0),
			atrial_pace_in ? apb_q : '0);
		len[CH_RCH] = mx(mx(atrial_pace_in ? rap_q : '0,
			right_chamber_pace_in ? rpb_q : '0),
			(three_ch && left_chamber_pace_in) ? lpb_q : '0);
		len[CH_LCH] = mx(mx(atrial_pace_in ? LCH_APACE_LEN : '0,
			(three_ch && right_chamber_pace_in) ? rpb_q : '0),
			(three_ch && left_chamber_pace_in) ? lpb_q : '0);
		en[CH_ATR] = ctrl_q[CTRL_ATR_EN];
		en[CH_RCH] = 1'b1;
		en[CH_LCH] = ctrl_q[CTRL_LCH_EN] && three_ch;
		pace[CH_ATR] = atrial_pace_in;
		pace[CH_RCH] = right_chamber_pace_in;
		pace[CH_LCH] = left_chamber_pace_in;
		amp[CH_ATR] = atrial_amp_in;
		amp[CH_RCH] = right_chamber_amp_in;
		amp[CH_LCH] = left_chamber_amp_in;
		stream_d = en;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stream_q <= '0;
		end else begin
			stream_q <= stream_d;
		end
	end

	for (genvar c = 0; c < 3; c++) begin : g_ch
		csb_channel u_ch (
			.clk_in(ref_clk_in),
			.rst_n_in(rst_n_in),
			.ms_tick_in(ms_tick),
			.sample_tick_in(samp_tick),
			.enable_in(en[c]),
			.amp_in(amp[c]),
			.pace_in(pace[c]),
			.blank_len_in(len[c]),
			.upper_pct_in(upct_q),
			.lower_pct_in(lpct_q),
			.min_thr_in(min_q),
			.dur_sense_in(dsen_q),
			.dur_pace_in(dpac_q),
			.twave_in(tw_q),
			.sense_out(sense[c]),
			.rate_out(rate[c]),
			.blanked_out(blanked[c]),
			.noise_out(noise[c]),
			.async_out(async_v[c]),
			.upper_out(upper[c]),
			.peak_out(peak[c])
		);
	end

	assign atrial_sense_event_out = sense[CH_ATR];
	assign atrial_rate_event_out = rate[CH_ATR];
	assign ventricular_sense_event_out = sense[CH_RCH];
	assign ventricular_rate_event_out = rate[CH_RCH];
	assign left_chamber_sense_event_out = sense[CH_LCH];
	assign async_pace_out = async_v[CH_RCH];
	assign intracardiac_waveform_stream_en_out = stream_q;
	assign record_en_out = stream_q;
endmodule

/* bench/csb_lead_model.sv */
// csb_lead_model: lead side, supplies sampled amplitudes per chamber.
// assumes the caller runs one beat at a time on the block clock.
`timescale 1ns/100ps
module csb_lead_model import csb_pkg::*; (
	// clock
	input wire logic clk_in,
	// amplitudes
	output logic [AW-1:0] atrial_amp_out,
	output logic [AW-1:0] right_chamber_amp_out,
	output logic [AW-1:0] left_chamber_amp_out
);
	logic [AW-1:0] amp_q [3] = '{default: '0};
	assign atrial_amp_out = amp_q[0];
	assign right_chamber_amp_out = amp_q[1];
	assign left_chamber_amp_out = amp_q[2];
	// each level outlasts one sample period
	task automatic pulse(input int ch, input logic [AW-1:0] amp);
		@(posedge clk_in);
		amp_q[ch] <= amp;
		repeat (12) @(posedge clk_in);
		amp_q[ch] <= '0;
		repeat (12) @(posedge clk_in);
	endtask
endmodule

/* bench/csb_sense_blanking_monitor.sv */
// csb_sense_blanking_monitor: port assertions for the blanking block.
// assumes blank lengths of several ms and sample ticks 8+ cycles apart.
`timescale 1ns/100ps
module csb_sense_blanking_monitor import csb_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// pace events
	input wire logic atrial_pace_in,
	input wire logic right_chamber_pace_in,
	input wire logic left_chamber_pace_in,
	// qualified events
	input wire logic atrial_sense_event_out,
	input wire logic atrial_rate_event_out,
	input wire logic ventricular_sense_event_out,
	input wire logic ventricular_rate_event_out,
	input wire logic left_chamber_sense_event_out,
	// enables
	input wire logic [2:0] intracardiac_waveform_stream_en_out,
	input wire logic [2:0] record_en_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence v_quiet;
		!ventricular_sense_event_out [*8];
	endsequence
	sequence a_quiet;
		!atrial_sense_event_out [*8];
	endsequence
	sequence l_quiet;
		!left_chamber_sense_event_out [*8];
	endsequence
	a_rpace_blanks_right: assert property (
		right_chamber_pace_in |-> ##2 v_quiet)
		else $error("right sense just after right pace");
	a_vpace_blanks_atrium: assert property (
		right_chamber_pace_in |-> ##2 a_quiet)
		else $error("atrial sense just after ventricular pace");
	a_apace_blanks_atrium: assert property (
		atrial_pace_in |-> ##2 a_quiet)
		else $error("atrial sense just after atrial pace");
	a_apace_blanks_vent: assert property (
		atrial_pace_in |-> ##2 v_quiet)
		else $error("right sense just after atrial pace");
	a_lpace_blanks_left: assert property (
		left_chamber_pace_in |-> ##2 l_quiet)
		else $error("left sense just after left pace");
	a_vsense_far_field: assert property (
		ventricular_sense_event_out |-> ##1 a_quiet)
		else $error("atrial sense inside far-field window");
	a_vrate_needs_sense: assert property (
		ventricular_rate_event_out |-> ventricular_sense_event_out)
		else $error("right rate event without sense");
	a_arate_needs_sense: assert property (
		atrial_rate_event_out |-> atrial_sense_event_out)
		else $error("atrial rate event without sense");
	a_atrial_off_silent: assert property (
		atrial_sense_event_out |->
		intracardiac_waveform_stream_en_out[0])
		else $error("atrial sense while atrial stream off");
	a_left_off_silent: assert property (
		left_chamber_sense_event_out |->
		intracardiac_waveform_stream_en_out[2])
		else $error("left sense while left stream off");
	a_record_follows: assert property (
		record_en_out == intracardiac_waveform_stream_en_out)
		else $error("recording enable differs from stream");
endmodule
bind csb_sense_blanking csb_sense_blanking_monitor u_mon (
	.ref_clk_in, .rst_n_in,
	.atrial_pace_in, .right_chamber_pace_in, .left_chamber_pace_in,
	.atrial_sense_event_out, .atrial_rate_event_out,
	.ventricular_sense_event_out, .ventricular_rate_event_out,
	.left_chamber_sense_event_out, .intracardiac_waveform_stream_en_out,
	.record_en_out);

/* bench/csb_sense_blanking_test.sv */
// csb_sense_blanking_test: beats from one random amplitude, directed paces and register accesses.
// assumes 10-cycle samples and 4-cycle ms for short windows.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module csb_sense_blanking_test;
	import csb_pkg::*;
	logic ref_clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [3:0] reg_addr_in = '0;
	logic [DW-1:0] reg_wdata_in = '0, reg_rdata_out;
	logic [2:0] pc = '0, st, rec;
	logic [4:0] ev;
	logic async_pace_out;
	logic [AW-1:0] atrial_amp_in, right_chamber_amp_in, left_chamber_amp_in;
	int n_fail = 0, num_checks = 0, cnt[5] = '{default: 0};
	csb_lead_model u_lead (.clk_in(ref_clk_in), .atrial_amp_out(atrial_amp_in),
		.right_chamber_amp_out(right_chamber_amp_in),
		.left_chamber_amp_out(left_chamber_amp_in));
	csb_sense_blanking #(.SAMPLE_CYCLES(10), .MS_CYCLES(4)) u_dut (
		.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .atrial_pace_in(pc[0]),
		.right_chamber_pace_in(pc[1]), .left_chamber_pace_in(pc[2]),
		.atrial_amp_in, .right_chamber_amp_in, .left_chamber_amp_in,
		.atrial_sense_event_out(ev[0]), .atrial_rate_event_out(ev[1]),
		.ventricular_sense_event_out(ev[2]),
		.ventricular_rate_event_out(ev[3]),
		.left_chamber_sense_event_out(ev[4]), .async_pace_out,
		.intracardiac_waveform_stream_en_out(st), .record_en_out(rec));
	initial begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		if (rst_n_in && $isunknown(ev))
			`CHK(ev, 5'h00)
		for (int i = 0; i < 5; i++)
			if (ev[i] === 1'b1)
				cnt[i]++;
	end
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [DW-1:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [DW-1:0] e);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		`CHK(reg_rdata_out, e)
	endtask
	task automatic pace(input int w);
		@(posedge ref_clk_in);
		pc[w] <= 1'b1;
		@(posedge ref_clk_in);
		pc[w] <= 1'b0;
	endtask
	// one beat, then sense and rate counts on that channel
	task automatic beat(input int ch, input logic [AW-1:0] amp, input int es,
		input int er);
		int b0, b1;
		b0 = cnt[2 * ch];
		b1 = (ch < 2) ? cnt[2 * ch + 1] : 0;
		u_lead.pulse(ch, amp);
		idle(2);
		#1;
		`CHK(cnt[2 * ch] - b0, es)
		if (ch < 2)
			`CHK(cnt[2 * ch + 1] - b1, er)
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#300000;
		n_fail++;
		conclude();
	end
	initial begin
		logic [AW-1:0] a, p, lt;
		void'($urandom(2013));
		a = 8'd60 + AW'($urandom % 140);
		p = a >> 1;
		lt = p >> 2;
		idle(8);
		rst_n_in <= 1'b1;
		idle(3);
		`CHK(st, 3'b011)
		`CHK(rec, 3'b011)
		rd(REG_UPPER_PCT, 16'h0032);
		rd(REG_LOWER_PCT, 16'h0019);
		rd(REG_UP_DUR_SENSE, 16'h015e);
		rd(REG_UP_DUR_PACE, 16'h0190);
		wr(REG_RCH_PEAK, 16'h00aa);
		rd(REG_RCH_PEAK, 16'h0000);
		wr(4'hf, 16'h1234);
		rd(4'hf, 16'h0000);
		beat(1, a, 1, 1);
		idle(500);
		beat(1, p - 8'd1, 0, 0);
		beat(1, p, 1, 1);
		beat(1, p, 1, 0);
		repeat (9) beat(1, p, 1, 0);
		`CHK(async_pace_out, 1'b1)
		idle(600);
		`CHK(async_pace_out, 1'b0)
		idle(1500);
		beat(1, lt - 8'd1, 0, 0);
		beat(1, lt, 1, 1);
		wr(REG_MIN_THR, 16'h0060);
		idle(1500);
		beat(1, 8'h5f, 0, 0);
		beat(1, 8'h60, 1, 1);
		wr(REG_MIN_THR, 16'h0004);
		idle(500);
		pace(1);
		beat(0, 8'h60, 0, 0);
		beat(1, 8'h60, 0, 0);
		idle(450);
		beat(1, 8'h2f, 0, 0);
		beat(1, 8'h30, 1, 1);
		idle(450);
		beat(0, 8'h60, 1, 1);
		idle(500);
		beat(1, 8'hff, 1, 1);
		beat(0, 8'h60, 0, 0);
		idle(500);
		pace(0);
		beat(0, 8'h60, 0, 0);
		beat(1, 8'hff, 0, 0);
		idle(300);
		wr(REG_CTRL, 16'h0002);
		idle(3);
		`CHK(st[0], 1'b0)
		`CHK(rec[0], 1'b0)
		beat(0, 8'h60, 0, 0);
		wr(REG_CTRL, 16'h000f);
		idle(3);
		`CHK(st, 3'b111)
		`CHK(rec, 3'b111)
		beat(2, 8'h60, 1, 0);
		pace(2);
		beat(2, 8'h60, 0, 0);
		beat(1, 8'hff, 0, 0);
		wr(REG_CTRL, 16'h000d);
		idle(3);
		`CHK(st, 3'b011)
		`CHK(rec, 3'b011)
		idle(400);
		beat(2, 8'h60, 0, 0);
		conclude();
	end
endmodule
